// >>> bft_core.v
// per-phase breaker failure trip logic with register port and interrupt
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`include "bft_map.vh"
`default_nettype none

module bft_core #(
  parameter NPH = 3,
  parameter [16:0] P_MS_CYC = `BFT_CLK_KHZ * `BFT_TICK_MS,
  parameter [25:0] P_PULSE_CYC = `BFT_PULSE_MS * `BFT_CLK_KHZ
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output wire o_irq,
  input wire [NPH-1:0] i_fail_initiate_first_ext,
  input wire [NPH-1:0] i_fail_initiate_first_int,
  input wire [NPH-1:0] i_fail_initiate_second_ext,
  input wire [NPH-1:0] i_fail_initiate_second_int,
  input wire [NPH-1:0] i_overcurrent,
  input wire [2:0] i_breaker_closed_contact,
  input wire i_test_stage1,
  input wire i_test_stage2,
  input wire i_block,
  output reg [NPH-1:0] o_trip_stage1,
  output reg [NPH-1:0] o_trip_stage2,
  output reg [NPH-1:0] o_sup_alarm,
  output reg [NPH-1:0] o_pickup
);

  // software registers
  reg [`BFT_CTRL_W-1:0] ctrl_ff;
  reg [`BFT_DLY_W-1:0] dly1_ff;
  reg [`BFT_DLY_W-1:0] dly2_ff;
  reg [`BFT_DLY_W-1:0] dly3_ff;
  reg [`BFT_EV_W-1:0] stat_ff;
  reg [`BFT_EV_W-1:0] mask_ff;
  reg [`BFT_EV_W-1:0] nxt_stat;
  reg [31:0] nxt_rdata;

  // millisecond tick prescaler
  reg [16:0] pre_ff;
  reg tick_ff;

  // per-phase state
  reg [NPH-1:0] fired1_ff;
  reg [NPH-1:0] fired2_ff;
  reg [NPH-1:0] nxt_pickup;
  reg [NPH-1:0] nxt_alarm;
  reg [NPH-1:0] nxt_trip1;
  reg [NPH-1:0] nxt_trip2;
  reg [NPH-1:0] nxt_fired1;
  reg [NPH-1:0] nxt_fired2;

  wire [NPH-1:0] init;
  wire [NPH-1:0] crit;
  wire [NPH-1:0] go1;
  wire [NPH-1:0] go2;
  wire [NPH-1:0] exp1;
  wire [NPH-1:0] exp2;
  wire [NPH-1:0] exp3;
  wire [NPH-1:0] pend1;
  wire [NPH-1:0] pend2;
  wire [NPH-1:0] end1;
  wire [NPH-1:0] end2;
  wire [NPH-1:0] fire1;
  wire [NPH-1:0] fire2;

  wire sel_first;
  wire sel_second;
  wire blk1;
  wire blk2;
  wire breaker_closed;
  wire wr_stat;

  assign sel_first = ctrl_ff[`BFT_CTRL_SEL_FIRST];
  assign sel_second = ctrl_ff[`BFT_CTRL_SEL_SECOND];

  // block input steered onto the stages chosen in the control register
  assign blk1 = i_block & ctrl_ff[`BFT_CTRL_BLK_S1];
  assign blk2 = i_block & ctrl_ff[`BFT_CTRL_BLK_S2];

  // all three contacts must show closed; unused ones are wired high
  assign breaker_closed = &i_breaker_closed_contact;

  // ms tick: stage delays count whole milliseconds, so they may end up to
  // one tick early; the trip pulse counts raw cycles and is exact
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else if (pre_ff == P_MS_CYC - 17'h00001) begin
      pre_ff <= 17'h00000;
      tick_ff <= 1'b1;
    end else begin
      pre_ff <= pre_ff + 17'h00001;
      tick_ff <= 1'b0;
    end
  end

  // per-phase datapath
  genvar p;
  generate
    for (p = 0; p < NPH; p = p + 1) begin : g_ph
      wire first_src;
      wire second_src;

      // source of each initiation picked by software
      assign first_src = sel_first ? i_fail_initiate_first_int[p]
                                   : i_fail_initiate_first_ext[p];
      assign second_src = sel_second ? i_fail_initiate_second_int[p]
                                     : i_fail_initiate_second_ext[p];
      assign init[p] = first_src | second_src;

      // either current or contact position proves a failure
      assign crit[p] = i_overcurrent[p] | breaker_closed;

      // test forces the criterion, but only beside an initiation
      assign go1[p] = crit[p] | (i_test_stage1 & init[p]);
      assign go2[p] = crit[p] | (i_test_stage2 & init[p]);

      // both stage delays run off the same pickup level
      bft_timer #(.W(`BFT_DLY_W)) u_dly1 (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_run(o_pickup[p]),
        .i_tick(tick_ff),
        .i_limit(dly1_ff),
        .o_expired(exp1[p])
      );

      bft_timer #(.W(`BFT_DLY_W)) u_dly2 (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_run(o_pickup[p]),
        .i_tick(tick_ff),
        .i_limit(dly2_ff),
        .o_expired(exp2[p])
      );

      // supervision runs on initiation alone, whatever the criterion
      bft_timer #(.W(`BFT_DLY_W)) u_sup (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_run(init[p] & ~o_sup_alarm[p]),
        .i_tick(tick_ff),
        .i_limit(dly3_ff),
        .o_expired(exp3[p])
      );

      // pulse length counts raw cycles from a fixed constant
      bft_timer #(.W(26)) u_pls1 (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_run(o_trip_stage1[p]),
        .i_tick(1'b1),
        .i_limit(P_PULSE_CYC - 26'h0000001),
        .o_expired(end1[p])
      );

      bft_timer #(.W(26)) u_pls2 (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_run(o_trip_stage2[p]),
        .i_tick(1'b1),
        .i_limit(P_PULSE_CYC - 26'h0000001),
        .o_expired(end2[p])
      );

      assign pend1[p] = o_pickup[p] & ~fired1_ff[p] & ~exp3[p];
      assign pend2[p] = o_pickup[p] & ~fired2_ff[p] & ~exp3[p];

      // each stage fires once per pickup; stage two rechecks the criterion
      assign fire1[p] = pend1[p] & exp1[p] & go1[p] & ~blk1;
      assign fire2[p] = pend2[p] & exp2[p] & go2[p] & ~blk2;
    end
  endgenerate

  // next state of pickup, alarm, fired flags and trip pulses
  always @* begin
    // pickup latches on coincidence and drops when initiation goes
    nxt_pickup = init & ~o_sup_alarm & ~exp3 & (o_pickup | go1 | go2);
    // supervision expiry clears the stages and holds until initiation drops
    nxt_alarm = init & (o_sup_alarm | exp3);
    nxt_fired1 = nxt_pickup & (fired1_ff | fire1);
    nxt_fired2 = nxt_pickup & (fired2_ff | fire2);
    // pulses end only on their own count, never on initiation loss
    nxt_trip1 = (o_trip_stage1 & ~end1) | fire1;
    nxt_trip2 = (o_trip_stage2 & ~end2) | fire2;
  end

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pickup <= {NPH{1'b0}};
      o_sup_alarm <= {NPH{1'b0}};
      fired1_ff <= {NPH{1'b0}};
      fired2_ff <= {NPH{1'b0}};
      o_trip_stage1 <= {NPH{1'b0}};
      o_trip_stage2 <= {NPH{1'b0}};
    end else begin
      o_pickup <= nxt_pickup;
      o_sup_alarm <= nxt_alarm;
      fired1_ff <= nxt_fired1;
      fired2_ff <= nxt_fired2;
      o_trip_stage1 <= nxt_trip1;
      o_trip_stage2 <= nxt_trip2;
    end
  end

  // sticky events: a new event in the clearing cycle survives the clear
  assign wr_stat = i_wr && (i_addr == `BFT_OFS_STAT);

  always @* begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & ~i_wdata[`BFT_EV_W-1:0];
    end
    nxt_stat[`BFT_EV_TRIP1] = nxt_stat[`BFT_EV_TRIP1] | (|fire1);
    nxt_stat[`BFT_EV_TRIP2] = nxt_stat[`BFT_EV_TRIP2] | (|fire2);
    nxt_stat[`BFT_EV_ALARM] = nxt_stat[`BFT_EV_ALARM] | (|(nxt_alarm & ~o_sup_alarm));
    nxt_stat[`BFT_EV_PICKUP] = nxt_stat[`BFT_EV_PICKUP] | (|(nxt_pickup & ~o_pickup));
  end

  // register writes; unmapped addresses are ignored
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_ff <= `BFT_CTRL_RST;
      dly1_ff <= `BFT_DLY1_RST;
      dly2_ff <= `BFT_DLY2_RST;
      dly3_ff <= `BFT_DLY3_RST;
      mask_ff <= `BFT_MASK_RST;
      stat_ff <= {`BFT_EV_W{1'b0}};
    end else begin
      stat_ff <= nxt_stat;
      if (i_wr) begin
        case (i_addr)
          `BFT_OFS_CTRL: begin
            ctrl_ff <= i_wdata[`BFT_CTRL_W-1:0];
          end
          `BFT_OFS_DLY1: begin
            dly1_ff <= i_wdata[`BFT_DLY_W-1:0];
          end
          `BFT_OFS_DLY2: begin
            dly2_ff <= i_wdata[`BFT_DLY_W-1:0];
          end
          `BFT_OFS_DLY3: begin
            dly3_ff <= i_wdata[`BFT_DLY_W-1:0];
          end
          `BFT_OFS_MASK: begin
            mask_ff <= i_wdata[`BFT_EV_W-1:0];
          end
          default: begin
            ctrl_ff <= ctrl_ff;
          end
        endcase
      end
    end
  end

  // read mux; data stands only in the cycle after the strobe
  always @* begin
    nxt_rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        `BFT_OFS_CTRL: begin
          nxt_rdata[`BFT_CTRL_W-1:0] = ctrl_ff;
        end
        `BFT_OFS_DLY1: begin
          nxt_rdata[`BFT_DLY_W-1:0] = dly1_ff;
        end
        `BFT_OFS_DLY2: begin
          nxt_rdata[`BFT_DLY_W-1:0] = dly2_ff;
        end
        `BFT_OFS_DLY3: begin
          nxt_rdata[`BFT_DLY_W-1:0] = dly3_ff;
        end
        `BFT_OFS_STAT: begin
          nxt_rdata[`BFT_EV_W-1:0] = stat_ff;
        end
        `BFT_OFS_MASK: begin
          nxt_rdata[`BFT_EV_W-1:0] = mask_ff;
        end
        `BFT_OFS_STATE: begin
          nxt_rdata[`BFT_ST_PICKUP +: NPH] = o_pickup;
          nxt_rdata[`BFT_ST_TRIP1 +: NPH] = o_trip_stage1;
          nxt_rdata[`BFT_ST_TRIP2 +: NPH] = o_trip_stage2;
          nxt_rdata[`BFT_ST_ALARM +: NPH] = o_sup_alarm;
        end
        default: begin
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= nxt_rdata;
    end
  end

  // level interrupt while any unmasked event stays pending
  assign o_irq = |(stat_ff & mask_ff);

endmodule // bft_core

`default_nettype wire

// >>> bft_map.vh
// register map, field positions, reset values and timing constants of the trip logic
`ifndef BFT_MAP_VH
`define BFT_MAP_VH

// register byte offsets
`define BFT_OFS_CTRL 8'h00
`define BFT_OFS_DLY1 8'h04
`define BFT_OFS_DLY2 8'h08
`define BFT_OFS_DLY3 8'h0C
`define BFT_OFS_STAT 8'h10
`define BFT_OFS_MASK 8'h14
`define BFT_OFS_STATE 8'h18

// control register fields
`define BFT_CTRL_SEL_FIRST 0
`define BFT_CTRL_SEL_SECOND 1
`define BFT_CTRL_BLK_S1 2
`define BFT_CTRL_BLK_S2 3
`define BFT_CTRL_W 4
`define BFT_CTRL_RST 4'hC

// delay registers, in milliseconds
`define BFT_DLY_W 16
`define BFT_DLY1_RST 16'h0096
`define BFT_DLY2_RST 16'h012C
`define BFT_DLY3_RST 16'h1388

// status and mask fields
`define BFT_EV_TRIP1 0
`define BFT_EV_TRIP2 1
`define BFT_EV_ALARM 2
`define BFT_EV_PICKUP 3
`define BFT_EV_W 4
`define BFT_MASK_RST 4'h0

// state register field positions
`define BFT_ST_PICKUP 0
`define BFT_ST_TRIP1 4
`define BFT_ST_TRIP2 8
`define BFT_ST_ALARM 12

// timing
`define BFT_CLK_KHZ 100000
`define BFT_TICK_MS 1
`define BFT_PULSE_MS 500

`endif

// >>> bft_timer.v
// elapsed-time counter that runs while enabled and flags when a limit is reached
`default_nettype none

module bft_timer #(
  parameter W = 16
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_run,
  input wire i_tick,
  input wire [W-1:0] i_limit,
  output wire o_expired
);

  reg [W-1:0] count_ff;
  reg [W-1:0] nxt_count;

  // count advances on each tick while running, holds at the limit, clears when idle
  always @* begin
    nxt_count = count_ff;
    if (!i_run) begin
      nxt_count = {W{1'b0}};
    end else if (i_tick && (count_ff != i_limit)) begin
      nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_ff <= {W{1'b0}};
    end else begin
      count_ff <= nxt_count;
    end
  end

  // a limit of zero expires at once while running
  assign o_expired = i_run && (count_ff == i_limit);

endmodule // bft_timer

`default_nettype wire

// >>> bft_far.sv
// far-side model: upstream protection relays and breaker contacts
`default_nettype none
module bft_far (
  input wire logic i_init,
  input wire logic i_stuck,
  input wire logic i_closed,
  output logic [2:0] o_init,
  output logic [2:0] o_oc,
  output logic [2:0] o_contact
);
  timeunit 1ns;
  timeprecision 1ps;
  // one upstream trip command and one fault current, seen by every phase
  assign o_init = {3{i_init}};
  assign o_oc = {3{i_stuck}};
  // two mechanical trips stay closed, so the aux contact alone decides
  assign o_contact = i_closed ? 3'h7 : 3'h3;
endmodule // bft_far
`default_nettype wire

// >>> bft_props.sv
// assertion checker for the breaker failure trip logic, phase 0
`default_nettype none
module bft_props #(
  parameter NPH = 3,
  parameter [25:0] P_PULSE_CYC = 26'h32
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [NPH-1:0] o_trip_stage1,
  input wire logic [NPH-1:0] o_trip_stage2,
  input wire logic [NPH-1:0] o_sup_alarm,
  input wire logic [NPH-1:0] o_pickup
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [25:0] c1_ff;
  logic [25:0] c2_ff;
  // pulse age; a repetition cannot span the full dwell
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      c1_ff <= 26'h0;
      c2_ff <= 26'h0;
    end else begin
      c1_ff <= o_trip_stage1[0] ? c1_ff + 26'h1 : 26'h0;
      c2_ff <= o_trip_stage2[0] ? c2_ff + 26'h1 : 26'h0;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_fire1; $rose(o_trip_stage1[0]); endsequence
  sequence s_fire2; $rose(o_trip_stage2[0]); endsequence
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  property p_len1; $fell(o_trip_stage1[0]) |-> c1_ff == P_PULSE_CYC; endproperty
  property p_len2; $fell(o_trip_stage2[0]) |-> c2_ff == P_PULSE_CYC; endproperty
  property p_hold1; s_fire1 |-> o_trip_stage1[0] [*8]; endproperty
  property p_pick1; s_fire1 |-> $past(o_pickup[0]); endproperty
  property p_pick2; s_fire2 |-> $past(o_pickup[0]); endproperty
  property p_sup_clr; $rose(o_sup_alarm[0]) |-> ##[0:2] !o_pickup[0]; endproperty
  property p_sup_quiet;
    o_sup_alarm[0] |-> !$rose(o_trip_stage1[0]) && !$rose(o_trip_stage2[0]);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_len1: assert property (p_len1) else $error("stage 1 dwell wrong");
  a_len2: assert property (p_len2) else $error("stage 2 dwell wrong");
  a_hold1: assert property (p_hold1) else $error("stage 1 pulse cut");
  a_pick1: assert property (p_pick1) else $error("trip 1 without pickup");
  a_pick2: assert property (p_pick2) else $error("trip 2 without pickup");
  a_sup_clr: assert property (p_sup_clr) else $error("alarm left pickup");
  a_sup_quiet: assert property (p_sup_quiet) else $error("trip under alarm");
endmodule // bft_props
bind bft_core bft_props #(.NPH(NPH), .P_PULSE_CYC(P_PULSE_CYC)) u_props (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_trip_stage1(o_trip_stage1), .o_trip_stage2(o_trip_stage2),
  .o_sup_alarm(o_sup_alarm), .o_pickup(o_pickup));
`default_nettype wire

// >>> tb_breaker_failure_trip_logic.sv
// self-checking bench for the breaker failure trip logic
`default_nettype none
module tb_breaker_failure_trip_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_rst_b, i_wr, i_rd, ini, stuck, closed, ini2, t1, t2, blk, o_irq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0] f_init, f_oc, f_con, trip1, trip2, alarm, pick;
  int err_count = 0, checks = 0, cyc = 0;
  wire [4:0] mon = {o_irq, alarm[0], trip2[0], trip1[0], pick[0]};
  bft_far far (.i_init(ini), .i_stuck(stuck), .i_closed(closed), .o_init(f_init),
    .o_oc(f_oc), .o_contact(f_con));
  // 1 ms = 10 cycles, dwell = 50 cycles, keeps the run short
  bft_core #(.P_MS_CYC(17'hA), .P_PULSE_CYC(26'h32)) dut (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .i_fail_initiate_first_ext(f_init),
    .i_fail_initiate_first_int({3{ini2}}), .i_fail_initiate_second_ext(3'h0),
    .i_fail_initiate_second_int({3{ini2}}), .i_overcurrent(f_oc),
    .i_breaker_closed_contact(f_con), .i_test_stage1(t1), .i_test_stage2(t2),
    .i_block(blk), .o_trip_stage1(trip1), .o_trip_stage2(trip2), .o_sup_alarm(alarm),
    .o_pickup(pick));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(n, o_rdata, e);
  endtask
  // bits: init, current, aux closed, internal first and second, test1, test2, block
  task automatic drv(input logic [6:0] v);
    {ini, stuck, closed, ini2, t1, t2, blk} <= v;
  endtask
  // expect a monitored output to go high within n cycles, or to stay low
  task automatic wt(input int s, input int n, input logic e, input string nm);
    logic hit = 1'b0;
    repeat (n) begin
      @(posedge i_ref_clk);
      #1 hit = hit | mon[s];
      if (hit) break;
    end
    chk(nm, {31'h0, hit}, {31'h0, e});
  endtask
  // long enough for any dwell to finish, then clear all events
  task automatic idle();
    drv(7'h00);
    repeat (70) @(posedge i_ref_clk);
    wr(8'h10, 32'hF);
  endtask
  task automatic t_regs();
    rd(8'h00, 32'hC, "ctrl");
    rd(8'h04, 32'h96, "dly1");
    rd(8'h08, 32'h12C, "dly2");
    rd(8'h0C, 32'h1388, "dly3");
    rd(8'h14, 32'h0, "mask");
    rd(8'h1C, 32'h0, "hole");
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h4);
    wr(8'h0C, 32'h1E);
    wr(8'h14, 32'hF);
    rd(8'h08, 32'h4, "dly2 back");
  endtask
  task automatic t_two();
    drv(7'h60);
    wt(1, 40, 1'b1, "trip1");
    wt(2, 30, 1'b1, "trip2");
    rd(8'h10, 32'hB, "status");
    wt(4, 1, 1'b1, "irq set");
    wr(8'h10, 32'hF);
    drv(7'h20);
    repeat (2) @(posedge i_ref_clk);
    wt(0, 5, 1'b0, "pickup drop");
    wt(4, 5, 1'b0, "irq clear");
    idle();
  endtask
  task automatic t_gate();
    drv(7'h60);
    wt(1, 40, 1'b1, "gate trip1");
    drv(7'h40);
    wt(2, 60, 1'b0, "gate trip2");
    idle();
  endtask
  task automatic t_crit();
    drv(7'h40);
    wt(0, 20, 1'b0, "aux open");
    drv(7'h50);
    wt(0, 5, 1'b1, "aux closed");
    idle();
    // picked up and tripped phase, cleared by supervision expiry
    drv(7'h50);
    wt(3, 320, 1'b1, "alarm");
    wt(0, 1, 1'b0, "pickup alarm");
    rd(8'h10, 32'hF, "alarm status");
    idle();
  endtask
  task automatic t_test();
    drv(7'h04);
    wt(0, 20, 1'b0, "test alone");
    drv(7'h44);
    wt(1, 40, 1'b1, "test trip1");
    idle();
    drv(7'h42);
    wt(2, 50, 1'b1, "test trip2");
    idle();
  endtask
  task automatic t_blk();
    logic [3:0] c [3] = '{4'h4, 4'h8, 4'hC};
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {28'h0, c[i]});
      drv(7'h61);
      repeat (60) @(posedge i_ref_clk);
      rd(8'h10, 32'h8 | {30'h0, ~c[i][3], ~c[i][2]}, "blocked");
      idle();
    end
  endtask
  task automatic t_sec();
    wr(8'h00, 32'h2);
    drv(7'h28);
    wt(0, 5, 1'b1, "second internal");
    idle();
    wr(8'h00, 32'h0);
    drv(7'h28);
    wt(0, 10, 1'b0, "internal unrouted");
    idle();
    wr(8'h00, 32'h1);
    drv(7'h28);
    wt(0, 5, 1'b1, "first internal");
    idle();
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    {ini, stuck, closed, ini2, t1, t2, blk} = 7'h00;
    repeat (8) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_two();
    t_gate();
    t_crit();
    t_test();
    t_blk();
    t_sec();
    report_and_stop();
  end
  // hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      report_and_stop();
    end
  end
endmodule // tb_breaker_failure_trip_logic
`default_nettype wire
